// >>> logic/wireless_channel_manager.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE1 - One to eight concurrent logical channels
// RULE2 - Master owns timing; slave follows master
// RULE3 - Slave replies only when configured to
// RULE4 - Eight byte payload, broadcast or acknowledged
// RULE5 - Burst extends the slot for more packets
// RULE6 - 20 kbps shared by slots in turn
// RULE7 - No new data: master resends last packet
// RULE8 - Period per channel, 5.2 ms to 2 s
// RULE9 - One of 78 frequencies per channel
// RULE10 - Four roles: two slaves, master, receive-only
// RULE11 - Identity: type byte, device byte, number
// RULE12 - Every packet carries the channel identity
// RULE13 - Period, frequency, role, network must agree
// RULE14 - Per channel network key filters peers
// RULE15 - Reset leaves every channel on public network
// RULE16 - Master broadcasts its whole identity
// RULE17 - Host sets identity before opening master
// RULE18 - Host sets identity for specific pairing
// RULE19 - Wild card field matches any value
// RULE20 - Slave captures unknown identity on connect
// RULE21 - Roles independent between channels
module wireless_channel_manager #(
   parameter int TICK_CYC = wcm_pkg::TICK_NS / wcm_pkg::CLK_NS, // Cycles per 100 us
   parameter int SLOT_CYC = wcm_pkg::SLOT_NS / wcm_pkg::CLK_NS  // Cycles a slot holds air
) (
   input  wire logic                         i_clk_sys,          // System clock
   input  wire logic                         i_reset_n,          // Async reset
   input  wire logic [8:0]                   i_avs_address,      // Byte address
   input  wire logic                         i_avs_read,         // Read request
   input  wire logic                         i_avs_write,        // Write request
   input  wire logic [31:0]                  i_avs_writedata,    // Write data
   input  wire logic [3:0]                   i_avs_byteenable,   // Byte lanes
   output logic [31:0]                       o_avs_readdata,     // Read data
   output logic                              o_avs_waitrequest,  // Stall master
   output logic                              o_tx_valid,         // Packet offered
   input  wire logic                         i_tx_ready,         // Radio takes it
   output wcm_pkg::pkt_t                     o_tx,               // Packet to send
   input  wire logic                         i_rx_valid,         // Packet heard
   input  wire wcm_pkg::pkt_t                i_rx,               // Heard packet
   output logic [wcm_pkg::NUM_CH-1:0]        o_locked            // Slave in step
);

   // ==========================================================
   // Reset image
   localparam wcm_pkg::chan_t CH_RST = '{
      open:   1'b0,
      role:   wcm_pkg::ROLE_BI_SLAVE,
      mode:   wcm_pkg::MODE_BCAST,
      freq:   wcm_pkg::FREQ_RST,
      period: wcm_pkg::PER_RST,
      key:    wcm_pkg::KEY_PUBLIC,    // RULE15
      default: '0
   };
   localparam logic [23:0] TICK_END = 24'(TICK_CYC - 1); // Divider wrap
   localparam logic [23:0] SLOT_END = 24'(SLOT_CYC - 1); // Air time wrap

   wcm_pkg::st_t               st;       // All state
   wcm_pkg::st_t               next_st;  // Next state
   logic [wcm_pkg::NUM_CH-1:0] hit;      // Filter result per channel
   logic                       tick;     // One period unit passed
   logic                       found;    // A slot owner chosen
   logic [2:0]                 pick;     // Chosen channel
   logic [2:0]                 wc;       // Channel under bus write
   logic [31:0]                w;        // Merged write word

   // ==========================================================
   // Helpers
   // Byte lanes not enabled keep the old contents
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction

   // Out of range periods are held to the legal window
   function automatic logic [14:0] per_lim(input logic [14:0] p);
      if (p < wcm_pkg::PER_MIN) begin
         return wcm_pkg::PER_MIN;  // RULE8
      end else if (p > wcm_pkg::PER_MAX) begin
         return wcm_pkg::PER_MAX;  // RULE8
      end
      return p;
   endfunction

   // Control word as software sees it
   function automatic logic [31:0] ctrl_word(input wcm_pkg::chan_t c);
      logic [31:0] r;
      r = '0;
      r[wcm_pkg::CTRL_OPEN]      = c.open;
      r[wcm_pkg::CTRL_ROLE +: 2] = c.role;
      r[wcm_pkg::CTRL_MODE +: 2] = c.mode;
      r[wcm_pkg::CTRL_REPLY]     = c.reply_en;
      r[wcm_pkg::CTRL_FREQ +: 7] = c.freq;
      return r;
   endfunction

   // Read decode; unmapped words read zero
   function automatic logic [31:0] rd_word(input wcm_pkg::st_t s, input logic [8:0] a);
      logic [31:0]   r;
      wcm_pkg::chan_t c;
      r = '0;
      c = s.ch[a[7:5]];
      if (!a[8]) begin
         case (a[4:0])
            wcm_pkg::OFS_CTRL:   r = ctrl_word(c);
            wcm_pkg::OFS_PERIOD: r = {17'h0_0000, c.period};
            wcm_pkg::OFS_ID:     r = c.id;  // RULE20
            wcm_pkg::OFS_WILD:   r = {29'h0000_0000, c.wild};
            wcm_pkg::OFS_KEY:    r = c.key;
            wcm_pkg::OFS_TXLO:   r = c.txd[31:0];
            wcm_pkg::OFS_TXHI:   r = c.txd[63:32];
            wcm_pkg::OFS_STAT: begin
               r[wcm_pkg::STAT_LOCK]  = c.locked;
               r[wcm_pkg::STAT_RXNEW] = c.rx_new;
               r[wcm_pkg::STAT_TXPND] = c.fresh;
            end
            default: r = '0;
         endcase
      end else if (a == wcm_pkg::OFS_CAPS) begin
         r = 32'(wcm_pkg::NUM_CH);  // RULE1
      end else if (a[8:6] == wcm_pkg::OFS_RX_BASE[8:6]) begin
         r = a[2] ? s.ch[a[5:3]].rxd[63:32] : s.ch[a[5:3]].rxd[31:0];
      end
      return r;
   endfunction

   // ==========================================================
   // Per channel filters
   generate
      for (genvar g = 0; g < wcm_pkg::NUM_CH; g++) begin : g_ch
         // Masters never search, so their wild cards are ignored
         wcm_id_match u_match (
            .i_rx   (i_rx),
            .i_freq (st.ch[g].freq),
            .i_key  (st.ch[g].key),
            .i_id   (st.ch[g].id),
            .i_wild ((st.ch[g].role == wcm_pkg::ROLE_BI_MASTER) ? 3'h0 : st.ch[g].wild),
            .o_hit  (hit[g])
         );
         assign o_locked[g] = st.ch[g].locked;
      end
   endgenerate

   // ==========================================================
   // Bus side signals
   assign wc                = i_avs_address[7:5];
   assign tick              = (st.tick_cnt == TICK_END);
   assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~st.ack; // One stall cycle
   assign o_avs_readdata    = st.rdata;
   assign o_tx_valid        = st.tx_valid;
   assign o_tx              = st.tx;

   // ==========================================================
   // Next state
   always_comb begin
      next_st = st;
      found   = 1'b0;
      pick    = 3'h0;
      w       = '0;

      // Bus handshake: stall one cycle, then answer
      next_st.ack = (i_avs_read | i_avs_write) & ~st.ack;
      if (i_avs_read && !st.ack) begin
         next_st.rdata = rd_word(st, i_avs_address);  // Stands at the answer edge
      end

      // Period unit divider
      next_st.tick_cnt = tick ? 24'h00_0000 : st.tick_cnt + 24'h00_0001;

      // Period counters, each channel on its own
      for (int c = 0; c < wcm_pkg::NUM_CH; c++) begin
         if (!st.ch[c].open) begin
            // Closed channel holds no timing
            next_st.ch[c].cnt       = '0;
            next_st.ch[c].locked    = 1'b0;
            next_st.ch[c].due       = 1'b0;
            next_st.ch[c].reply_due = 1'b0;
         end else if (tick) begin
            if (st.ch[c].cnt >= per_lim(st.ch[c].period) - 15'h0001) begin
               next_st.ch[c].cnt = '0;  // RULE8
               // Only a master starts an exchange
               if (st.ch[c].role == wcm_pkg::ROLE_BI_MASTER) begin
                  next_st.ch[c].due = 1'b1;  // RULE2 RULE21
               end
            end else begin
               next_st.ch[c].cnt = st.ch[c].cnt + 15'h0001;
            end
         end
      end

      // Air access: one channel at a time
      case (st.med)
         wcm_pkg::MED_IDLE: begin
            // A burst keeps the air while the host keeps feeding it
            if (st.burst_hold && st.ch[st.burst_ch].open && st.ch[st.burst_ch].fresh) begin
               found = 1'b1;  // RULE5
               pick  = st.burst_ch;
            end else begin
               next_st.burst_hold = 1'b0;
               // Descending scan so the lowest waiting channel wins
               for (int c = wcm_pkg::NUM_CH - 1; c >= 0; c--) begin
                  if (st.ch[c].open && (st.ch[c].due || st.ch[c].reply_due)) begin
                     found = 1'b1;  // RULE6
                     pick  = 3'(c);
                  end
               end
            end
            if (found) begin
               next_st.tx.chan    = pick;
               next_st.tx.freq    = st.ch[pick].freq;   // RULE9
               next_st.tx.key     = st.ch[pick].key;    // RULE14
               next_st.tx.id      = st.ch[pick].id;     // RULE12 RULE16
               next_st.tx.ack_req = (st.ch[pick].mode == wcm_pkg::MODE_ACK);  // RULE4
               next_st.tx.reply   = (st.ch[pick].role != wcm_pkg::ROLE_BI_MASTER);
               // Stale payload is sent again to keep the slot alive
               next_st.tx.payload = st.ch[pick].txd;    // RULE7 RULE4
               next_st.ch[pick].due       = 1'b0;
               next_st.ch[pick].reply_due = 1'b0;
               next_st.ch[pick].fresh     = 1'b0;
               next_st.burst_hold = (st.ch[pick].role == wcm_pkg::ROLE_BI_MASTER)
                                    && (st.ch[pick].mode == wcm_pkg::MODE_BURST);  // RULE5
               next_st.burst_ch   = pick;
               next_st.tx_valid   = 1'b1;
               next_st.med        = wcm_pkg::MED_SEND;
            end
         end
         wcm_pkg::MED_SEND: begin
            // Packet stands until the radio takes it
            if (i_tx_ready) begin
               next_st.tx_valid = 1'b0;
               next_st.slot_cnt = '0;
               next_st.med      = wcm_pkg::MED_GUARD;
            end
         end
         wcm_pkg::MED_GUARD: begin
            // Air time of one slot; this caps the sum of all channels
            if (st.slot_cnt == SLOT_END) begin
               next_st.med = wcm_pkg::MED_IDLE;  // RULE6
            end else begin
               next_st.slot_cnt = st.slot_cnt + 24'h00_0001;
            end
         end
         default: begin
            next_st.med      = wcm_pkg::MED_IDLE;
            next_st.tx_valid = 1'b0;
         end
      endcase

      // Register writes land on the answer edge only
      if (i_avs_write && st.ack && !i_avs_address[8]) begin
         case (i_avs_address[4:0])
            wcm_pkg::OFS_CTRL: begin
               w = merge(ctrl_word(st.ch[wc]), i_avs_writedata, i_avs_byteenable);
               next_st.ch[wc].open     = w[wcm_pkg::CTRL_OPEN];
               next_st.ch[wc].role     = wcm_pkg::role_t'(w[wcm_pkg::CTRL_ROLE +: 2]);  // RULE10
               next_st.ch[wc].mode     = wcm_pkg::mode_t'(w[wcm_pkg::CTRL_MODE +: 2]);
               next_st.ch[wc].reply_en = w[wcm_pkg::CTRL_REPLY];
               // Frequencies beyond the last are held to the last
               next_st.ch[wc].freq = (w[wcm_pkg::CTRL_FREQ +: 7] > wcm_pkg::FREQ_LAST)
                                     ? wcm_pkg::FREQ_LAST : w[wcm_pkg::CTRL_FREQ +: 7];  // RULE9
               // Opening starts a fresh timing and a fresh search
               if (w[wcm_pkg::CTRL_OPEN] && !st.ch[wc].open) begin
                  next_st.ch[wc].cnt    = '0;
                  next_st.ch[wc].locked = 1'b0;
                  next_st.ch[wc].due    = 1'b0;
               end
            end
            wcm_pkg::OFS_PERIOD: begin
               w = merge({17'h0_0000, st.ch[wc].period}, i_avs_writedata, i_avs_byteenable);
               next_st.ch[wc].period = w[14:0];  // RULE8
            end
            wcm_pkg::OFS_ID: begin
               next_st.ch[wc].id = merge(st.ch[wc].id, i_avs_writedata, i_avs_byteenable);  // RULE11
            end
            wcm_pkg::OFS_WILD: begin
               w = merge({29'h0000_0000, st.ch[wc].wild}, i_avs_writedata, i_avs_byteenable);
               next_st.ch[wc].wild = w[2:0];  // RULE19
            end
            wcm_pkg::OFS_KEY: begin
               next_st.ch[wc].key = merge(st.ch[wc].key, i_avs_writedata, i_avs_byteenable);  // RULE14
            end
            wcm_pkg::OFS_TXLO: begin
               next_st.ch[wc].txd[31:0] = merge(st.ch[wc].txd[31:0], i_avs_writedata, i_avs_byteenable);
            end
            wcm_pkg::OFS_TXHI: begin
               // High word commits the packet; it wins over a send
               next_st.ch[wc].txd[63:32] = merge(st.ch[wc].txd[63:32], i_avs_writedata, i_avs_byteenable);
               next_st.ch[wc].fresh      = 1'b1;
            end
            wcm_pkg::OFS_STAT: begin
               // Write one clears the new data flag
               if (i_avs_byteenable[0] && i_avs_writedata[wcm_pkg::STAT_RXNEW]) begin
                  next_st.ch[wc].rx_new = 1'b0;
               end
            end
            default: begin
               // Unmapped offsets ignore writes
            end
         endcase
      end

      // Heard packets, after the bus so a set beats a clear
      if (i_rx_valid) begin
         for (int c = 0; c < wcm_pkg::NUM_CH; c++) begin
            if (st.ch[c].open && hit[c]) begin
               if (st.ch[c].role == wcm_pkg::ROLE_BI_MASTER) begin
                  // Master takes back data from its slave only
                  if (i_rx.reply) begin
                     next_st.ch[c].rxd    = i_rx.payload;
                     next_st.ch[c].rx_new = 1'b1;
                  end
               end else if (!i_rx.reply) begin
                  // Slave locks onto the master's slot
                  next_st.ch[c].locked = 1'b1;          // RULE2
                  next_st.ch[c].cnt    = '0;            // RULE2
                  next_st.ch[c].id     = i_rx.id;       // RULE20
                  next_st.ch[c].rxd    = i_rx.payload;  // RULE4
                  next_st.ch[c].rx_new = 1'b1;
                  // Receive-only slaves never answer
                  if (st.ch[c].role != wcm_pkg::ROLE_RX_SLAVE && st.ch[c].reply_en) begin
                     next_st.ch[c].reply_due = 1'b1;  // RULE3
                  end
               end
            end
         end
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st <= '{ch: '{default: CH_RST}, med: wcm_pkg::MED_IDLE, default: '0};  // RULE15
      end else begin
         st <= next_st;
      end
   end

endmodule
`default_nettype wire

// >>> logic/wcm_pkg.sv
`default_nettype none
package wcm_pkg;
   // ==========================================================
   // Sizes and timing
   localparam int NUM_CH  = 8;          // Channels of this build
   localparam int CLK_NS  = 8;          // 125 MHz system clock
   localparam int TICK_NS = 100_000;    // Period unit, 100 us
   localparam int SLOT_NS = 3_200_000;  // 64 bits at 20 kbps
   localparam logic [14:0] PER_MIN   = 15'h0034;     // 5.2 ms
   localparam logic [14:0] PER_MAX   = 15'h4E20;     // 2 s
   localparam logic [14:0] PER_RST   = 15'h0148;     // Period after reset
   localparam logic [6:0]  FREQ_RST  = 7'h42;        // Frequency after reset
   localparam logic [6:0]  FREQ_LAST = 7'h4D;        // 78 frequencies
   localparam logic [31:0] KEY_PUBLIC = 32'h0000_0000; // Open network
   // ==========================================================
   // Register offsets, byte addresses
   localparam logic [4:0] OFS_CTRL   = 5'h00; // Per channel, stride 0x20
   localparam logic [4:0] OFS_PERIOD = 5'h04;
   localparam logic [4:0] OFS_ID     = 5'h08;
   localparam logic [4:0] OFS_WILD   = 5'h0C;
   localparam logic [4:0] OFS_KEY    = 5'h10;
   localparam logic [4:0] OFS_TXLO   = 5'h14;
   localparam logic [4:0] OFS_TXHI   = 5'h18;
   localparam logic [4:0] OFS_STAT   = 5'h1C;
   localparam logic [8:0] OFS_RX_BASE = 9'h100; // Stride 8, low then high
   localparam logic [8:0] OFS_CAPS    = 9'h180; // Channel count
   // ==========================================================
   // Field positions
   localparam int CTRL_OPEN  = 0;
   localparam int CTRL_ROLE  = 1;  // Two bits
   localparam int CTRL_MODE  = 3;  // Two bits
   localparam int CTRL_REPLY = 5;
   localparam int CTRL_FREQ  = 6;  // Seven bits
   localparam int STAT_LOCK  = 0;
   localparam int STAT_RXNEW = 1;
   localparam int STAT_TXPND = 2;
   // ==========================================================
   // Types
   typedef enum logic [1:0] {ROLE_BI_SLAVE, ROLE_BI_MASTER, ROLE_SHARED_SLAVE, ROLE_RX_SLAVE} role_t;
   typedef enum logic [1:0] {MODE_BCAST, MODE_ACK, MODE_BURST} mode_t;
   typedef enum logic [1:0] {MED_IDLE, MED_SEND, MED_GUARD} med_t;
   typedef struct packed {
      logic [15:0] dev_num;   // Device number
      logic [7:0]  dev_type;  // Device type
      logic [7:0]  tx_type;   // Transmission type
   } id_t;
   typedef struct packed {
      logic [2:0]  chan;      // Local channel index
      logic [6:0]  freq;      // Radio frequency index
      logic [31:0] key;       // Network key
      id_t         id;        // Channel identity
      logic        ack_req;   // Receiver asked to acknowledge
      logic        reply;     // Sent by a slave
      logic [63:0] payload;   // Eight payload bytes
   } pkt_t;
   typedef struct packed {
      logic        open;
      role_t       role;
      mode_t       mode;
      logic        reply_en;
      logic [6:0]  freq;
      logic [14:0] period;
      id_t         id;
      logic [2:0]  wild;      // Wild card per identity field
      logic [31:0] key;
      logic [63:0] txd;
      logic [63:0] rxd;
      logic        fresh;     // Host gave new payload
      logic        locked;
      logic        rx_new;
      logic        due;
      logic        reply_due;
      logic [14:0] cnt;
   } chan_t;
   typedef struct packed {
      chan_t [NUM_CH-1:0] ch;
      med_t        med;
      logic        ack;
      logic [31:0] rdata;
      logic [23:0] tick_cnt;
      logic [23:0] slot_cnt;
      logic        tx_valid;
      pkt_t        tx;
      logic        burst_hold;
      logic [2:0]  burst_ch;
   } st_t;
endpackage
`default_nettype wire

// >>> logic/wcm_id_match.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Identity and network filter for one channel
module wcm_id_match (
   input  wire wcm_pkg::pkt_t i_rx,     // Heard packet
   input  wire logic [6:0]    i_freq,   // Channel frequency
   input  wire logic [31:0]   i_key,    // Channel network key
   input  wire wcm_pkg::id_t  i_id,     // Channel identity
   input  wire logic [2:0]    i_wild,   // Wild cards, tx/type/number
   output logic               o_hit     // Packet belongs to channel
);
   logic f_tx;    // Transmission type agrees
   logic f_type;  // Device type agrees
   logic f_num;   // Device number agrees

   // A wild card accepts any value in its field
   assign f_tx   = i_wild[0] | (i_rx.id.tx_type == i_id.tx_type);   // RULE19
   assign f_type = i_wild[1] | (i_rx.id.dev_type == i_id.dev_type); // RULE19
   assign f_num  = i_wild[2] | (i_rx.id.dev_num == i_id.dev_num);   // RULE19

   // Network must agree exactly; public key only meets public
   assign o_hit = f_tx & f_type & f_num & (i_rx.freq == i_freq) & (i_rx.key == i_key); // RULE14 RULE13
endmodule
`default_nettype wire

// >>> verification/wireless_channel_manager_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port checks on the channel manager
module wcm_monitor (
   input wire logic                  i_clk_sys,         // Clock
   input wire logic                  i_reset_n,         // Reset
   input wire logic                  i_avs_read,        // Read
   input wire logic                  i_avs_write,       // Write
   input wire logic [31:0]           o_avs_readdata,    // Read data
   input wire logic                  o_avs_waitrequest, // Stall
   input wire logic                  o_tx_valid,        // Offer
   input wire logic                  i_tx_ready,        // Taken
   input wire wcm_pkg::pkt_t         o_tx,              // Packet
   input wire logic                  i_rx_valid,        // Heard
   input wire logic [7:0]            o_locked           // Locks
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_reset_n);
   wait_one_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("stall longer than one cycle");
   idle_nowait_a: assert property (!(i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
      else $error("stall without request");
   rdata_hold_a: assert property (!i_avs_read |=> $stable(o_avs_readdata))
      else $error("read data moved without read");
   tx_hold_a: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx))
      else $error("offer changed before taken");
   tx_air_a: assert property (o_tx_valid && i_tx_ready |=> !o_tx_valid [*4])
      else $error("offer while air busy");
   lock_cause_a: assert property ((o_locked & ~$past(o_locked)) != '0 |-> $past(i_rx_valid))
      else $error("lock without heard packet");
   reply_lock_a: assert property ($rose(o_tx_valid) && o_tx.reply |-> o_locked != '0)
      else $error("reply from unlocked slave");
   freq_range_a: assert property (o_tx_valid |-> o_tx.freq <= wcm_pkg::FREQ_LAST)
      else $error("frequency out of range");
endmodule
bind wireless_channel_manager wcm_monitor wcm_monitor_inst (.i_clk_sys, .i_reset_n, .i_avs_read,
   .i_avs_write, .o_avs_readdata, .o_avs_waitrequest, .o_tx_valid, .i_tx_ready, .o_tx, .i_rx_valid, .o_locked);
`default_nettype wire

// >>> verification/wcm_radio_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Radio stand-in: takes packets, plays heard ones
module wcm_radio_model (
   input  wire logic          i_clk,      // Clock
   input  wire logic          i_slow,     // Stall ready three cycles
   input  wire logic          i_tx_valid, // Offer
   input  wire wcm_pkg::pkt_t i_tx,       // Offered packet
   output logic               o_tx_ready, // Taken
   output logic               o_rx_valid, // Heard pulse
   output wcm_pkg::pkt_t      o_rx        // Heard packet
);
   wcm_pkg::pkt_t last;  // Last packet taken
   wcm_pkg::pkt_t nxt;   // Packet to play
   int            got;   // Packets taken
   int            hold;  // Stall count
   logic          req;   // Play pending
   initial begin
      {o_tx_ready, o_rx_valid, req} = '0;
      {got, hold} = '0;
      o_rx = '0;
   end
   // ==========================================
   // Heard packets only as the bench commands through hear
   always @(posedge i_clk) begin
      o_tx_ready <= 1'b0;
      if (i_tx_valid && o_tx_ready) begin
         last <= i_tx;
         got  <= got + 1;
      end else if (i_tx_valid) begin
         hold <= hold + 1;
         if (!i_slow || hold >= 3) o_tx_ready <= 1'b1;
      end else hold <= 0;
      o_rx_valid <= req;
      o_rx       <= req ? nxt : ~o_rx; // Idle lines toggle, never stale
      req = 1'b0;
   end
   task automatic hear(input wcm_pkg::pkt_t p);
      @(negedge i_clk);
      nxt = p;
      req = 1'b1;
      @(posedge i_clk);
      @(negedge i_clk);
   endtask
endmodule
`default_nettype wire

// >>> verification/wireless_channel_manager_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Bench: register bus calls, radio stand-in
module wireless_channel_manager_tb_top;
   localparam int W = $bits(wcm_pkg::pkt_t);
   logic          clk, rst_n, rd, we, wreq, txv, txr, rxv, slow;
   logic [8:0]    adr;
   logic [31:0]   wd, q, rdata;
   logic [7:0]    lk;
   wcm_pkg::pkt_t tx, rx, p;
   int            err_count, check_count, cyc, t1, t2;
   wireless_channel_manager #(.TICK_CYC(4), .SLOT_CYC(8)) wireless_channel_manager_inst (
      .i_clk_sys(clk), .i_reset_n(rst_n), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(we),
      .i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
      .o_tx_valid(txv), .i_tx_ready(txr), .o_tx(tx), .i_rx_valid(rxv), .i_rx(rx), .o_locked(lk));
   wcm_radio_model wcm_radio_model_inst (.i_clk(clk), .i_slow(slow), .i_tx_valid(txv), .i_tx(tx),
      .o_tx_ready(txr), .o_rx_valid(rxv), .o_rx(rx));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Hang guard: whole run needs under 2000 cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_count++;
         summarize();
      end
   end
   task automatic chk(input string n, input logic [W-1:0] e, input logic [W-1:0] s);
      check_count++;
      if (s !== e) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   // One bus access; held until waitrequest is seen low
   task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
      @(posedge clk);
      rd  <= !w;
      we  <= w;
      adr <= a;
      wd  <= d;
      do @(posedge clk); while (wreq !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic rchk(input logic [8:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      chk($sformatf("reg %h", a), W'(e), W'(q));
   endtask
   // Wait for the radio to take one more packet
   task automatic txwait(output int t);
      int n;
      n = wcm_radio_model_inst.got;
      repeat (400) if (wcm_radio_model_inst.got == n) @(posedge clk);
      if (wcm_radio_model_inst.got == n) err_count++;
      t = cyc;
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      {rst_n, rd, we, slow, adr, wd} = '0;
      {err_count, check_count, cyc} = '0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      rchk(9'h180, 32'h0000_0008);
      rchk(9'h1E4, 32'h0000_0000);
      for (int c = 0; c < 8; c++) begin
         rchk(9'(c * 32), 32'h0000_1080);
         rchk(9'(c * 32 + 16), 32'h0000_0000);
      end
      // Master on channel 1, period below the floor, slow radio
      slow <= 1'b1;
      bus(1'b1, 9'h028, 32'h1234_5678);
      bus(1'b1, 9'h030, 32'hA5A5_0001);
      bus(1'b1, 9'h024, 32'h0000_000A);
      bus(1'b1, 9'h034, 32'h0BAD_F00D);
      bus(1'b1, 9'h038, 32'h0123_4567);
      bus(1'b1, 9'h020, 32'h0000_014B);
      p = '{chan: 3'h1, freq: 7'h05, key: 32'hA5A5_0001, id: 32'h1234_5678, ack_req: 1'b1,
            reply: 1'b0, payload: 64'h0123_4567_0BAD_F00D};
      txwait(t1);
      chk("master pkt", p, wcm_radio_model_inst.last);
      txwait(t2);
      chk("resent pkt", p, wcm_radio_model_inst.last);
      chk("interval", W'(208), W'(t2 - t1));
      bus(1'b1, 9'h020, 32'h0000_1FC0);
      rchk(9'h020, 32'h0000_1340);
      // Slave on channel 0, device type fixed, others wild
      slow <= 1'b0;
      bus(1'b1, 9'h008, 32'h0000_3300);
      bus(1'b1, 9'h00C, 32'h0000_0005);
      bus(1'b1, 9'h000, 32'h0000_0261);
      p = '{chan: 3'h0, freq: 7'h09, key: 32'h0000_0001, id: 32'hBEEF_3301, ack_req: 1'b0,
            reply: 1'b0, payload: 64'h1111_2222_3333_4444};
      wcm_radio_model_inst.hear(p);
      @(negedge clk);
      chk("foreign key", W'(0), W'(lk[0]));
      p.key = 32'h0000_0000;
      wcm_radio_model_inst.hear(p);
      @(negedge clk);
      chk("lock", W'(1), W'(lk[0]));
      txwait(t1);
      chk("reply", W'(1), W'(wcm_radio_model_inst.last.reply));
      rchk(9'h008, 32'hBEEF_3301);
      rchk(9'h100, 32'h3333_4444);
      rchk(9'h104, 32'h1111_2222);
      summarize();
   end
endmodule
`default_nettype wire
